// ===== src/seic_pkg.sv
// Constants for the switch input edge interrupt qualification block.
// Assumes a register port that carries a 6-bit offset and 24-bit data words.
package seic_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         REG_AW      = 6;
	localparam int         REG_DW      = 24;
	localparam logic [5:0] SINGLE_OFS  = 6'h25;
	localparam logic [5:0] DUAL_OFS    = 6'h26;
	localparam logic [23:0] RESET_WORD = 24'h000000;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int SINGLE_CNT   = 5;   // Inputs 0..4 handled here
	localparam int SINGLE_FW    = 2;
	localparam int SINGLE_USED  = 10;  // Bits 9..0 of the single word
	localparam int DUAL_CNT     = 6;   // Inputs 12..17
	localparam int DUAL_FW      = 4;
	localparam int DUAL_FIRST   = 12;

	// Edge select encodings
	typedef enum logic [1:0] {
		SEIC_EDGE_NONE = 2'h0,
		SEIC_EDGE_RISE = 2'h1,
		SEIC_EDGE_FALL = 2'h2,
		SEIC_EDGE_BOTH = 2'h3
	} seic_edge_t;
endpackage : seic_pkg

// ===== src/seic_edge_qual.sv
// Edge qualifier for one threshold comparison of one switch input.
// Assumes the comparison result is already in the mclk domain.
`timescale 1ns/1ps
module seic_edge_qual (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       sample,
	input  wire logic       above,
	input  wire logic [1:0] edge_sel,
	output logic            irq_pulse
);
	import seic_pkg::*;

	logic prev_q;
	logic prev_ok_q;

	// ----------------------------------------------------------------
	// Previous comparison result
	// ----------------------------------------------------------------
	// The first sample after reset only seeds history, so no false edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prev_q    <= 1'b0;
			prev_ok_q <= 1'b0;
		end else if (ce && sample) begin
			prev_q    <= above;
			prev_ok_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Qualification, one pulse per transition
	// ----------------------------------------------------------------
	always_comb begin
		irq_pulse = 1'b0;
		if (ce && sample && prev_ok_q) begin
			case (seic_edge_t'(edge_sel))
				SEIC_EDGE_NONE: irq_pulse = 1'b0;
				SEIC_EDGE_RISE: irq_pulse = above & ~prev_q;
				SEIC_EDGE_FALL: irq_pulse = ~above & prev_q;
				SEIC_EDGE_BOTH: irq_pulse = above ^ prev_q;
				default:        irq_pulse = 1'b0;
			endcase
		end
	end
endmodule : seic_edge_qual

// ===== src/seic_top.sv
// Switch input edge interrupt configuration and qualification.
// Assumes a serial front end that turns host frames into single-cycle
// register strobes on mclk, and a comparator that presents per-input
// above-threshold results together with a sample strobe.
// Limitations
// Bits 23..10 of the single word are stored but qualify nothing here.
// A field change takes effect at the next sample strobe; the history of
// every comparison tracks samples whatever its field holds.
// Clock enable low freezes every flop, request pulses included.
`timescale 1ns/1ps
module seic_top (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	input  wire logic [seic_pkg::REG_AW-1:0]   reg_addr,
	input  wire logic [seic_pkg::REG_DW-1:0]   reg_wdata,
	output logic      [seic_pkg::REG_DW-1:0]   reg_rdata,
	output logic                               reg_rvalid,
	input  wire logic                          sample,
	input  wire logic [seic_pkg::SINGLE_CNT-1:0] selected_threshold,
	input  wire logic [seic_pkg::DUAL_CNT-1:0]   group_two_first_threshold,
	input  wire logic [seic_pkg::DUAL_CNT-1:0]   group_two_second_threshold,
	output logic      [seic_pkg::SINGLE_CNT-1:0] single_irq,
	output logic      [seic_pkg::DUAL_CNT-1:0]   dual_irq,
	output logic                               irq_any
);
	import seic_pkg::*;

	logic [REG_DW-1:0]       single_threshold_edge_irq_enables_q;
	logic [REG_DW-1:0]       dual_threshold_edge_irq_enables_q;
	logic [SINGLE_CNT-1:0]   single_hit;
	logic [DUAL_CNT-1:0]     first_hit;
	logic [DUAL_CNT-1:0]     second_hit;
	logic [SINGLE_CNT-1:0]   single_irq_q;
	logic [DUAL_CNT-1:0]     dual_irq_q;
	logic [REG_DW-1:0]       rdata_q;
	logic                    rvalid_q;
	logic                    wr_single;
	logic                    wr_dual;
	logic [SINGLE_FW-1:0]    switch_zero_edge_select;
	logic [SINGLE_FW-1:0]    switch_one_edge_select;
	logic [SINGLE_FW-1:0]    switch_two_edge_select;
	logic [SINGLE_FW-1:0]    switch_three_edge_select;
	logic [SINGLE_FW-1:0]    switch_four_edge_select;
	logic [DUAL_FW-1:0]      switch_twelve_edge_select;
	logic [DUAL_FW-1:0]      switch_thirteen_edge_select;
	logic [DUAL_FW-1:0]      switch_fourteen_edge_select;
	logic [DUAL_FW-1:0]      switch_fifteen_edge_select;
	logic [DUAL_FW-1:0]      switch_sixteen_edge_select;
	logic [DUAL_FW-1:0]      switch_seventeen_edge_select;
	logic [SINGLE_FW-1:0]    single_sel [SINGLE_CNT];
	logic [DUAL_FW-1:0]      dual_sel   [DUAL_CNT];

	// Offset decode, shared by the write and the read paths
	// Bit 0 selects the single word, bit 1 the dual word
	function automatic logic [1:0] decode(input logic [REG_AW-1:0] a);
		case (a)
			SINGLE_OFS: decode = 2'h1;
			DUAL_OFS:   decode = 2'h2;
			default:    decode = 2'h0;
		endcase
	endfunction : decode

	// Write strobes per word; ce low drops the write entirely
	assign wr_single = ce && reg_wr && (decode(reg_addr) == 2'h1);
	assign wr_dual   = ce && reg_wr && (decode(reg_addr) == 2'h2);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Bits above 9 of the single word belong to inputs this block does
	// not qualify; they are still stored so read-back stays honest.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			single_threshold_edge_irq_enables_q <= RESET_WORD;
			dual_threshold_edge_irq_enables_q   <= RESET_WORD;
		end else begin
			if (wr_single) begin
				single_threshold_edge_irq_enables_q <= reg_wdata;
			end
			if (wr_dual) begin
				dual_threshold_edge_irq_enables_q <= reg_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read-back, registered one cycle after the strobe
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero rather than holding stale data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q  <= RESET_WORD;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				case (decode(reg_addr))
					2'h1:    rdata_q <= single_threshold_edge_irq_enables_q;
					2'h2:    rdata_q <= dual_threshold_edge_irq_enables_q;
					default: rdata_q <= RESET_WORD;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Field views, one name per switch input
	// ----------------------------------------------------------------
	// Named slices keep the bit map in one place; the qualifier loops
	// below only ever index the gathered arrays.
	assign switch_zero_edge_select =
		single_threshold_edge_irq_enables_q[0*SINGLE_FW +: SINGLE_FW];
	assign switch_one_edge_select =
		single_threshold_edge_irq_enables_q[1*SINGLE_FW +: SINGLE_FW];
	assign switch_two_edge_select =
		single_threshold_edge_irq_enables_q[2*SINGLE_FW +: SINGLE_FW];
	assign switch_three_edge_select =
		single_threshold_edge_irq_enables_q[3*SINGLE_FW +: SINGLE_FW];
	assign switch_four_edge_select =
		single_threshold_edge_irq_enables_q[4*SINGLE_FW +: SINGLE_FW];
	assign switch_twelve_edge_select =
		dual_threshold_edge_irq_enables_q[0*DUAL_FW +: DUAL_FW];
	assign switch_thirteen_edge_select =
		dual_threshold_edge_irq_enables_q[1*DUAL_FW +: DUAL_FW];
	assign switch_fourteen_edge_select =
		dual_threshold_edge_irq_enables_q[2*DUAL_FW +: DUAL_FW];
	assign switch_fifteen_edge_select =
		dual_threshold_edge_irq_enables_q[3*DUAL_FW +: DUAL_FW];
	assign switch_sixteen_edge_select =
		dual_threshold_edge_irq_enables_q[4*DUAL_FW +: DUAL_FW];
	assign switch_seventeen_edge_select =
		dual_threshold_edge_irq_enables_q[5*DUAL_FW +: DUAL_FW];

	// Gathered by input index for the generate loops
	assign single_sel[0] = switch_zero_edge_select;
	assign single_sel[1] = switch_one_edge_select;
	assign single_sel[2] = switch_two_edge_select;
	assign single_sel[3] = switch_three_edge_select;
	assign single_sel[4] = switch_four_edge_select;
	assign dual_sel[0]   = switch_twelve_edge_select;
	assign dual_sel[1]   = switch_thirteen_edge_select;
	assign dual_sel[2]   = switch_fourteen_edge_select;
	assign dual_sel[3]   = switch_fifteen_edge_select;
	assign dual_sel[4]   = switch_sixteen_edge_select;
	assign dual_sel[5]   = switch_seventeen_edge_select;

	// ----------------------------------------------------------------
	// Single threshold inputs 0..4
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < SINGLE_CNT; gi++) begin : g_single
			seic_edge_qual u_qual (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.ce        (ce),
				.sample    (sample),
				.above     (selected_threshold[gi]),
				// Pair 2i+1..2i of the first word
				.edge_sel  (single_sel[gi]),
				.irq_pulse (single_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Dual threshold inputs 12..17
	// ----------------------------------------------------------------
	// Each nibble drives two separate qualifiers, so one zero pair
	// never masks the other threshold.
	generate
		for (gi = 0; gi < DUAL_CNT; gi++) begin : g_dual
			seic_edge_qual u_first (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.ce        (ce),
				.sample    (sample),
				.above     (group_two_first_threshold[gi]),
				.edge_sel  (dual_sel[gi][1:0]),
				.irq_pulse (first_hit[gi])
			);
			seic_edge_qual u_second (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.ce        (ce),
				.sample    (sample),
				.above     (group_two_second_threshold[gi]),
				.edge_sel  (dual_sel[gi][3:2]),
				.irq_pulse (second_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registered request pulses
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			single_irq_q <= '0;
			dual_irq_q   <= '0;
		end else if (ce) begin
			single_irq_q <= single_hit;
			dual_irq_q   <= first_hit | second_hit;
		end
	end

	assign single_irq = single_irq_q;
	assign dual_irq   = dual_irq_q;
	assign irq_any    = |{single_irq_q, dual_irq_q};
	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;
endmodule : seic_top

// ===== tb/seic_monitor.sv
// Port checker for seic_top, attached by bind.
// Assumes single-cycle strobes sampled on rising mclk.
`timescale 1ns/1ps
module seic_monitor (
	input wire logic                          mclk,
	input wire logic                          rst_n,
	input wire logic                          ce,
	input wire logic                          reg_rd,
	input wire logic [seic_pkg::REG_AW-1:0]   reg_addr,
	input wire logic [seic_pkg::REG_DW-1:0]   reg_rdata,
	input wire logic                          reg_rvalid,
	input wire logic                          sample,
	input wire logic [seic_pkg::SINGLE_CNT-1:0] single_irq,
	input wire logic [seic_pkg::DUAL_CNT-1:0]   dual_irq,
	input wire logic                          irq_any
);
	import seic_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Read handshake: answer exactly one cycle on
	chk_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
		else $error("read not answered");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(ce && reg_rd))
		else $error("stray read valid");
	// Reset edge guarded, a short reset would look like a data change
	chk_rdata_hold: assert property (rst_n && $past(rst_n) && !reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved");
	chk_unmapped_zero: assert property (ce && reg_rd && reg_addr != SINGLE_OFS
		&& reg_addr != DUAL_OFS |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	chk_any_or: assert property (irq_any == (|single_irq || |dual_irq))
		else $error("summary request wrong");
	chk_single_cause: assert property (|single_irq |-> $past(ce && sample))
		else $error("single request without sample");
	chk_dual_cause: assert property (|dual_irq |-> $past(ce && sample))
		else $error("dual request without sample");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !irq_any && !reg_rvalid)
		else $error("outputs busy after reset");
endmodule : seic_monitor

bind seic_top seic_monitor u_seic_monitor (.mclk, .rst_n, .ce, .reg_rd, .reg_addr, .reg_rdata,
	.reg_rvalid, .sample, .single_irq, .dual_irq, .irq_any);

// ===== tb/seic_host.sv
// Host model issuing register strobes to seic_top.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module seic_host (
	input  wire logic                        mclk,
	input  wire logic                        reg_rvalid,
	input  wire logic [seic_pkg::REG_DW-1:0] reg_rdata,
	output logic                             reg_wr,
	output logic                             reg_rd,
	output logic      [seic_pkg::REG_AW-1:0] reg_addr,
	output logic      [seic_pkg::REG_DW-1:0] reg_wdata
);
	import seic_pkg::*;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 24'h000000;
	end
	// Data inverted after the strobe so stale values are never trusted
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// Answer expected one cycle after the strobe edge
	task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask : rd
endmodule : seic_host

// ===== tb/test_seic_top.sv
// Self-checking bench for seic_top: registers and edge qualification.
// Assumes seic_host and seic_monitor are compiled first.
`timescale 1ns/1ps
module test_seic_top;
	import seic_pkg::*;
	logic        mclk, rst_n, ce, sample, reg_wr, reg_rd, reg_rvalid, irq_any, ok, fresh;
	logic [5:0]  reg_addr, group_two_first_threshold, group_two_second_threshold, dual_irq;
	logic [23:0] reg_wdata, reg_rdata, cfg1, cfg2, got;
	logic [4:0]  selected_threshold, single_irq;
	logic [31:0] seed;
	int          bad_count, check_count;
	seic_top u_seic_top (.mclk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .sample, .selected_threshold, .group_two_first_threshold,
		.group_two_second_threshold, .single_irq, .dual_irq, .irq_any);
	seic_host u_seic_host (.mclk, .reg_rvalid, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Edge qualification of one pair: previous vs current result
	function automatic logic q(input logic [1:0] f, input logic p, input logic c);
		return (f[0] && !p && c) || (f[1] && p && !c);
	endfunction : q
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rchk(input logic [5:0] a, input logic [23:0] e);
		u_seic_host.rd(a, got, ok);
		chk(24'(ok), 24'h000001);
		chk(got, e);
	endtask : rchk
	// Drive values still on the ports are the previous sample's history
	task automatic smp(input logic [4:0] s, input logic [5:0] a, input logic [5:0] b);
		logic [4:0] es;
		logic [5:0] ed;
		for (int i = 0; i < 5; i++) es[i] = !fresh && q(cfg1[2*i+:2], selected_threshold[i], s[i]);
		for (int i = 0; i < 6; i++) ed[i] = !fresh && (q(cfg2[4*i+:2], group_two_first_threshold[i],
			a[i]) || q(cfg2[4*i+2+:2], group_two_second_threshold[i], b[i]));
		@(posedge mclk);
		sample <= 1'b1;
		selected_threshold <= s;
		group_two_first_threshold <= a;
		group_two_second_threshold <= b;
		@(posedge mclk);
		sample <= 1'b0;
		#1;
		chk(24'(single_irq), 24'(es));
		chk(24'(dual_irq), 24'(ed));
		chk(24'(irq_any), 24'(|{es, ed}));
		fresh = 1'b0;
	endtask : smp
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		{ce, rst_n, sample, fresh} = 4'h9;
		{selected_threshold, group_two_first_threshold, group_two_second_threshold} = '0;
		{bad_count, check_count, cfg1, cfg2, seed} = {64'h0, 48'h0, 32'h109C};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rchk(SINGLE_OFS, RESET_WORD);
		rchk(DUAL_OFS, RESET_WORD);
		u_seic_host.wr(6'h27, 24'hFFFFFF);
		rchk(6'h27, 24'h000000);
		$display("test reset and map done");
		smp(5'h1F, 6'h3F, 6'h3F);
		// First pass: every edge enabled; later passes random words
		for (int n = 0; n < 256; n++) begin
			if (n % 16 == 0) begin
				seed = xs(seed);
				cfg1 = (n == 0) ? 24'h0003FF : seed[23:0];
				seed = xs(seed);
				cfg2 = (n == 0) ? 24'hFFFFFF : seed[23:0];
				u_seic_host.wr(SINGLE_OFS, cfg1);
				u_seic_host.wr(DUAL_OFS, cfg2);
				rchk(SINGLE_OFS, cfg1);
				rchk(DUAL_OFS, cfg2);
			end
			seed = xs(seed);
			smp(seed[4:0], seed[10:5], seed[16:11]);
		end
		$display("test random edges done");
		// Clock enable low: a write in that window must not land
		@(posedge mclk);
		ce <= 1'b0;
		u_seic_host.wr(SINGLE_OFS, ~cfg1);
		ce <= 1'b1;
		rchk(SINGLE_OFS, cfg1);
		$display("test clock enable done");
		finish_test();
	end
endmodule : test_seic_top
